// ===== hw/mrtmc_mode_control.sv
// Mode control of the MAC: control word, address filter, loopback and retry.

// Overview of operation
// R01: loop_return_select 0 means normal path, 1 means internal MII loopback.
// R02: In loopback, transmitted frames return to receive and never reach the PHY.
// R03: A loopback change completes within 10 us of the write.
// R04: Host stops both paths before changing loopback, waits 10 us after.
// R05: two_way_select gives simultaneous transfer and masks the heartbeat check.
// R06: group_pass_all accepts all multicast; unicast still needs a station match.
// R07: accept_any_dest accepts every frame regardless of destination.
// R08: reverse_match inverts the decision, only in perfect filtering mode.
// R09: keep_faulty_frames delivers filtered runts, collided and truncated frames.
// R10: hash_for_all_dest hash-filters both individual and multicast addresses.
// R11: hash_group_select 0 filters perfectly against the station address.
// R12: hash_group_select 1 hash-filters multicast; unicast depends on hash_for_all_dest.
// R13: late_hit_retry chooses retry or abandon on late collision; flag updated.
// R14: drop_broadcast rejects broadcast frames; otherwise all broadcasts pass.
// R15: single_attempt drops a collided frame and flags a retry error.
// R16: Without single_attempt, up to 16 attempts precede a retry error.
// R17: pad_trim with length field below 46 strips pad and check sequence.
// R18: Other frames, or pad_trim off, are delivered unmodified.
// R19: tx_path_on gates the transmitter; off means no frames sent.
// R20: rx_path_on gates the receiver; off means no frames accepted.
// R21: Reserved bits 14 and 9 read zero and writes to them do nothing.
module mrtmc_mode_control #(
   parameter int ATTEMPTS = mrtmc_pkg::MAX_ATTEMPTS
) (
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic [3:0]               csr_index_in,
   input  wire logic                     csr_wr_in,
   input  wire logic                     csr_rd_in,
   input  wire logic [31:0]              csr_wdata_in,
   output logic [31:0]                   csr_rdata_out,
   output logic                          csr_ack_out,
   input  wire logic [47:0]              station_addr_in,
   input  wire logic [63:0]              hash_table_in,
   input  wire logic                     dest_valid_in,
   input  wire logic [47:0]              dest_addr_in,
   output logic                          filt_done_out,
   output logic                          filt_pass_out,
   input  wire logic                     rx_end_in,
   input  wire mrtmc_pkg::mrtmc_rx_end_t rx_end_info_in,
   output logic                          rx_deliver_out,
   output logic                          rx_trim_out,
   input  wire logic                     tx_start_in,
   input  wire logic                     tx_coll_in,
   input  wire logic                     tx_late_in,
   output logic                          tx_go_out,
   output logic                          tx_retry_out,
   output logic                          tx_drop_out,
   output mrtmc_pkg::mrtmc_tx_stat_t     tx_stat_out,
   input  wire logic                     hb_fail_in,
   output logic                          hb_fail_out,
   output logic                          two_way_out,
   input  wire mrtmc_pkg::mrtmc_mii_t    mac_tx_in,
   output mrtmc_pkg::mrtmc_mii_t         phy_tx_out,
   input  wire mrtmc_pkg::mrtmc_mii_t    phy_rx_in,
   output mrtmc_pkg::mrtmc_mii_t         mac_rx_out,
   output logic                          loop_busy_out
);
   import mrtmc_pkg::*;

   localparam int SETTLE_MAX = 1000;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   function automatic mrtmc_ctrl_t decode_ctrl(input logic [31:0] w);
      mrtmc_ctrl_t c;
      c.loop        = w[LOOP_BIT];
      c.two_way     = w[TWO_WAY_BIT];
      c.group_all   = w[GROUP_ALL_BIT];
      c.any_dest    = w[ANY_DEST_BIT];
      c.reverse     = w[REVERSE_BIT];
      c.keep_faulty = w[KEEP_FAULTY_BIT];
      c.hash_all    = w[HASH_ALL_BIT];
      c.hash_group  = w[HASH_GROUP_BIT];
      c.late_retry  = w[LATE_RETRY_BIT];
      c.drop_drop_broadcast  = w[DROP_DROP_BROADCAST_BIT];
      c.single      = w[SINGLE_BIT];
      c.pad_trim    = w[PAD_TRIM_BIT];
      c.tx_on       = w[TX_ON_BIT];
      c.rx_on       = w[RX_ON_BIT];
      return c;
   endfunction : decode_ctrl

   // Hash index is the top six bits of the CRC-32 of the address, sent
   // least significant bit first, as the receive CRC sees it.
   function automatic logic [5:0] hash_index(input logic [47:0] a);
      logic [31:0] crc;
      logic        fb;
      crc = 32'hFFFF_FFFF;
      for (int i = 0; i < 48; i++) begin
         fb  = crc[31] ^ a[i];
         crc = {crc[30:0], 1'b0};
         if (fb) begin
            crc = crc ^ 32'h04C1_1DB7;
         end
      end
      return crc[31:26];
   endfunction : hash_index

   // Control word and register port.
   logic [31:0] ctrl_word_r;
   mrtmc_ctrl_t ctrl;
   logic        ctrl_sel;

   assign ctrl_sel = (csr_index_in == CTRL_INDEX);
   assign ctrl     = decode_ctrl(ctrl_word_r);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_word_r <= CTRL_RESET;
      end else if (csr_wr_in && ctrl_sel) begin
         ctrl_word_r <= csr_wdata_in & CTRL_RW_MASK; // R21
      end
   end

   // Reads answer one cycle later; unmapped indices read as zero.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         csr_rdata_out <= 32'h0000_0000;
         csr_ack_out   <= 1'b0;
      end else begin
         csr_ack_out <= csr_rd_in | csr_wr_in;
         if (csr_rd_in) begin
            csr_rdata_out <= ctrl_sel ? ctrl_word_r : 32'h0000_0000;
         end
      end
   end

   // Loopback changeover. The new mode is taken at an idle moment on the
   // MII so no frame is cut in half, but never later than the settle time.
   logic        loop_eff_r;
   logic [15:0] loop_cnt_r;
   logic        loop_pending;
   logic        mii_idle;

   assign loop_pending  = (ctrl.loop != loop_eff_r);
   assign mii_idle      = ~mac_tx_in.en & ~phy_rx_in.en;
   assign loop_busy_out = loop_pending;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         loop_eff_r <= 1'b0;
         loop_cnt_r <= 16'h0000;
      end else if (!loop_pending) begin
         loop_cnt_r <= 16'h0000;
      end else if (mii_idle ||
                   loop_cnt_r == 16'(LOOP_SETTLE_CYC - 1)) begin
         loop_eff_r <= ctrl.loop; // R03
         loop_cnt_r <= 16'h0000;
      end else begin
         loop_cnt_r <= loop_cnt_r + 16'h0001;
      end
   end

   // MII steering, one register stage in each direction.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         phy_tx_out <= '0;
         mac_rx_out <= '0;
      end else begin
         if (loop_eff_r || !ctrl.tx_on) begin
            phy_tx_out <= '0; // R02 R19
         end else begin
            phy_tx_out <= mac_tx_in; // R01
         end
         if (!ctrl.rx_on) begin
            mac_rx_out <= '0; // R20
         end else if (loop_eff_r) begin
            mac_rx_out <= mac_tx_in; // R01 R02
         end else begin
            mac_rx_out <= phy_rx_in;
         end
      end
   end

   // Duplex and heartbeat.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         two_way_out <= 1'b0;
         hb_fail_out <= 1'b0;
      end else begin
         two_way_out <= ctrl.two_way;
         hb_fail_out <= hb_fail_in & ~ctrl.two_way; // R05
      end
   end

   // Destination address filter.
   logic is_drop_broadcast;
   logic is_mcast;
   logic perfect_hit;
   logic hash_hit;
   logic perfect_mode;
   logic pass_now;

   assign is_drop_broadcast     = &dest_addr_in;
   assign is_mcast     = dest_addr_in[0];
   assign perfect_hit  = (dest_addr_in == station_addr_in);
   assign hash_hit     = hash_table_in[hash_index(dest_addr_in)];
   assign perfect_mode = ~ctrl.hash_group & ~ctrl.hash_all; // R11

   always_comb begin
      if (ctrl.any_dest) begin
         pass_now = 1'b1; // R07
      end else if (is_drop_broadcast) begin
         pass_now = ~ctrl.drop_drop_broadcast; // R14
      end else if (is_mcast) begin
         if (ctrl.group_all) begin
            pass_now = 1'b1; // R06
         end else if (ctrl.hash_group || ctrl.hash_all) begin
            pass_now = hash_hit; // R10 R12
         end else begin
            pass_now = perfect_hit ^ ctrl.reverse; // R08 R11
         end
      end else if (ctrl.hash_all) begin
         pass_now = hash_hit; // R10
      end else if (perfect_mode) begin
         pass_now = perfect_hit ^ ctrl.reverse; // R08 R11
      end else begin
         pass_now = perfect_hit; // R06 R12
      end
   end

   logic filt_pass_r;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         filt_done_out <= 1'b0;
         filt_pass_r   <= 1'b0;
      end else begin
         filt_done_out <= dest_valid_in;
         if (dest_valid_in) begin
            filt_pass_r <= pass_now & ctrl.rx_on; // R20
         end
      end
   end

   assign filt_pass_out = filt_pass_r;

   // End-of-frame delivery and pad trimming.
   logic bad_frame;

   assign bad_frame = rx_end_info_in.runt | rx_end_info_in.collided |
                      rx_end_info_in.truncated;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_deliver_out <= 1'b0;
         rx_trim_out    <= 1'b0;
      end else if (rx_end_in) begin
         rx_deliver_out <= filt_pass_r &
                           (~bad_frame | ctrl.keep_faulty); // R09
         rx_trim_out    <= ctrl.pad_trim &
                           (rx_end_info_in.length < PAD_MIN_LEN); // R17 R18
      end else begin
         rx_deliver_out <= 1'b0;
         rx_trim_out    <= 1'b0;
      end
   end

   // Transmit attempts. Full duplex has no collisions, so reports are
   // ignored there rather than trusted.
   logic [4:0] attempt_r;
   logic       coll_seen;

   assign coll_seen = tx_coll_in & ~ctrl.two_way; // R05
   assign tx_go_out = ctrl.tx_on & ~loop_pending; // R19 R04

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         attempt_r    <= 5'h01;
         tx_retry_out <= 1'b0;
         tx_drop_out  <= 1'b0;
         tx_stat_out  <= '0;
      end else begin
         tx_retry_out <= 1'b0;
         tx_drop_out  <= 1'b0;
         if (tx_start_in) begin
            attempt_r   <= 5'h01;
            tx_stat_out <= '0;
         end else if (coll_seen) begin
            if (tx_late_in) begin
               tx_stat_out.late_coll <= 1'b1; // R13
            end
            if (tx_late_in && !ctrl.late_retry) begin
               tx_drop_out <= 1'b1; // R13
            end else if (ctrl.single) begin
               tx_drop_out           <= 1'b1; // R15
               tx_stat_out.retry_err <= 1'b1; // R15
            end else if (attempt_r >= 5'(ATTEMPTS)) begin
               tx_drop_out           <= 1'b1; // R16
               tx_stat_out.retry_err <= 1'b1; // R16
            end else begin
               tx_retry_out <= 1'b1; // R13 R16
               attempt_r    <= attempt_r + 5'h01;
            end
         end
      end
   end

   AST_RESERVED_ZERO: assert property ( // R21
      csr_ack_out && $past(csr_rd_in) |->
         csr_rdata_out[14] == 1'b0 && csr_rdata_out[9] == 1'b0)
      else $error("reserved control bits read back nonzero");

   AST_LOOP_SETTLES: assert property ( // R03
      $changed(ctrl.loop) |-> ##[0:SETTLE_MAX] (loop_eff_r == ctrl.loop))
      else $error("loopback change not complete within settle time");

   AST_LOOP_NO_PHY: assert property ( // R02
      loop_eff_r && $past(loop_eff_r) |=> phy_tx_out.en == 1'b0)
      else $error("loopback frame leaked to the PHY");

   AST_LOOP_RETURN: assert property ( // R01
      loop_eff_r && ctrl.rx_on && !loop_pending |=>
         mac_rx_out == $past(mac_tx_in))
      else $error("loopback did not return transmit data");

   AST_TX_GATE: assert property ( // R19
      !ctrl.tx_on ##1 !ctrl.tx_on |-> phy_tx_out.en == 1'b0)
      else $error("transmitter active while disabled");

   AST_RX_GATE: assert property ( // R20
      !ctrl.rx_on ##1 !ctrl.rx_on |-> mac_rx_out.en == 1'b0)
      else $error("receiver active while disabled");

   AST_HEARTBEAT: assert property ( // R05
      $past(ctrl.two_way) |-> hb_fail_out == 1'b0)
      else $error("heartbeat fail reported in full duplex");

   AST_PROMISC: assert property ( // R07
      dest_valid_in && ctrl.any_dest && ctrl.rx_on |=>
         filt_done_out && filt_pass_out)
      else $error("promiscuous frame rejected");

   AST_DROP_BROADCAST_DROP: assert property ( // R14
      dest_valid_in && is_drop_broadcast && ctrl.drop_drop_broadcast && !ctrl.any_dest |=>
         !filt_pass_out)
      else $error("broadcast accepted while disabled");

   AST_SINGLE_TRY: assert property ( // R15
      coll_seen && !tx_start_in && ctrl.single &&
         !(tx_late_in && !ctrl.late_retry) |=>
         tx_drop_out && tx_stat_out.retry_err && !tx_retry_out)
      else $error("single attempt mode retried a frame");

   AST_RETRY_LIMIT: assert property ( // R16
      tx_retry_out |-> attempt_r <= 5'(ATTEMPTS))
      else $error("more attempts than the limit");

   AST_PAD_TRIM: assert property ( // R18
      rx_end_in && !ctrl.pad_trim |=> !rx_trim_out)
      else $error("frame trimmed with pad trimming off");

endmodule : mrtmc_mode_control

// ===== hw/mrtmc_pkg.sv
// Package with the control word layout, carriers and timing constants.
package mrtmc_pkg;

   localparam logic [3:0]  CTRL_INDEX    = 4'h1;
   localparam logic [31:0] CTRL_RESET    = 32'h0004_0000;
   localparam logic [31:0] CTRL_RW_MASK  = 32'h80BF_BDEC;

   localparam int LOOP_BIT        = 21;
   localparam int TWO_WAY_BIT     = 20;
   localparam int GROUP_ALL_BIT   = 19;
   localparam int ANY_DEST_BIT    = 18;
   localparam int REVERSE_BIT     = 17;
   localparam int KEEP_FAULTY_BIT = 16;
   localparam int HASH_ALL_BIT    = 15;
   localparam int HASH_GROUP_BIT  = 13;
   localparam int LATE_RETRY_BIT  = 12;
   localparam int DROP_DROP_BROADCAST_BIT  = 11;
   localparam int SINGLE_BIT      = 10;
   localparam int PAD_TRIM_BIT    = 8;
   localparam int TX_ON_BIT       = 3;
   localparam int RX_ON_BIT       = 2;

   localparam int CLK_PERIOD_NS   = 10;
   localparam int LOOP_SETTLE_NS  = 10000;
   localparam int LOOP_SETTLE_CYC = LOOP_SETTLE_NS / CLK_PERIOD_NS;
   localparam int MAX_ATTEMPTS    = 16;
   localparam logic [15:0] PAD_MIN_LEN = 16'h002E;

   typedef struct packed {
      logic loop;
      logic two_way;
      logic group_all;
      logic any_dest;
      logic reverse;
      logic keep_faulty;
      logic hash_all;
      logic hash_group;
      logic late_retry;
      logic drop_drop_broadcast;
      logic single;
      logic pad_trim;
      logic tx_on;
      logic rx_on;
   } mrtmc_ctrl_t;

   typedef struct packed {
      logic       en;
      logic [3:0] d;
   } mrtmc_mii_t;

   typedef struct packed {
      logic        runt;
      logic        collided;
      logic        truncated;
      logic [15:0] length;
   } mrtmc_rx_end_t;

   typedef struct packed {
      logic late_coll;
      logic retry_err;
   } mrtmc_tx_stat_t;

endpackage : mrtmc_pkg

// ===== verif/mrtmc_mode_control_tb_top.sv
// Self-checking testbench of the MAC mode control block.
module mrtmc_mode_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mrtmc_pkg::*;
   localparam logic [47:0] STA = 48'hBC9A_7856_3412;
   localparam logic [47:0] MIS = 48'hBC9A_7856_3410;
   localparam logic [47:0] MC  = 48'h0000_0000_0001;
   localparam logic [47:0] BC  = 48'hFFFF_FFFF_FFFF;
   logic clk_in, rst_in, csr_wr_in, csr_rd_in, dest_valid_in, rx_end_in;
   logic tx_start_in, tx_coll_in, tx_late_in, hb_fail_in, send;
   logic [3:0] csr_index_in;
   logic [31:0] csr_wdata_in, csr_rdata_out, q;
   logic [47:0] station_addr_in, dest_addr_in;
   logic [63:0] hash_table_in;
   mrtmc_rx_end_t rx_end_info_in;
   mrtmc_tx_stat_t tx_stat_out;
   mrtmc_mii_t mac_tx_in, phy_tx_out, phy_rx_in, mac_rx_out, p;
   logic csr_ack_out, filt_done_out, filt_pass_out, rx_deliver_out;
   logic rx_trim_out, tx_go_out, tx_retry_out, tx_drop_out, hb_fail_out;
   logic two_way_out, loop_busy_out;
   int err_total, num_checks, cyc, seen, n;

   mrtmc_mode_control u_mrtmc_mode_control (
      .clk_in, .rst_in, .csr_index_in, .csr_wr_in, .csr_rd_in,
      .csr_wdata_in, .csr_rdata_out, .csr_ack_out, .station_addr_in,
      .hash_table_in, .dest_valid_in, .dest_addr_in, .filt_done_out,
      .filt_pass_out, .rx_end_in, .rx_end_info_in, .rx_deliver_out,
      .rx_trim_out, .tx_start_in, .tx_coll_in, .tx_late_in, .tx_go_out,
      .tx_retry_out, .tx_drop_out, .tx_stat_out, .hb_fail_in,
      .hb_fail_out, .two_way_out, .mac_tx_in, .phy_tx_out, .phy_rx_in,
      .mac_rx_out, .loop_busy_out);
   mrtmc_phy_model u_mrtmc_phy_model (.clk_in, .send_in(send),
      .phy_tx_in(phy_tx_out), .phy_rx_out(phy_rx_in), .seen_out(seen));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic acc(input logic wr, input logic [3:0] i, logic [31:0] d);
      @(negedge clk_in);
      csr_wr_in = wr;
      csr_rd_in = !wr;
      csr_index_in = i;
      csr_wdata_in = d;
      @(posedge clk_in);
      #1;
      chk(csr_ack_out, 1'b1);
      q = csr_rdata_out;
      @(negedge clk_in);
      csr_wr_in = 1'b0;
      csr_rd_in = 1'b0;
   endtask : acc

   task automatic wr(input logic [31:0] d);
      acc(1'b1, 4'h1, d);
   endtask : wr

   task automatic filt(input logic [47:0] a, input logic e);
      @(negedge clk_in);
      dest_valid_in = 1'b1;
      dest_addr_in = a;
      @(posedge clk_in);
      #1;
      chk({filt_done_out, filt_pass_out}, {1'b1, e});
      @(negedge clk_in);
      dest_valid_in = 1'b0;
   endtask : filt

   task automatic fend(input logic [2:0] b, logic [15:0] l, logic dl, tr);
      @(negedge clk_in);
      rx_end_in = 1'b1;
      rx_end_info_in = {b, l};
      @(posedge clk_in);
      #1;
      chk({rx_deliver_out, rx_trim_out}, {dl, tr});
      @(negedge clk_in);
      rx_end_in = 1'b0;
   endtask : fend

   task automatic txe(input logic s, c, l, r, d, input logic [1:0] st);
      @(negedge clk_in);
      tx_start_in = s;
      tx_coll_in = c;
      tx_late_in = l;
      @(posedge clk_in);
      #1;
      chk({tx_retry_out, tx_drop_out, tx_stat_out}, {r, d, st});
      @(negedge clk_in);
      tx_start_in = 1'b0;
      tx_coll_in = 1'b0;
   endtask : txe

   task automatic t_regs();
      acc(1'b0, 4'h1, 32'h0);
      chk(q, 32'h0004_0000);
      wr(32'hFFDF_FFF3);
      acc(1'b0, 4'h1, 32'h0);
      chk(q, 32'h809F_BDE0);
      acc(1'b0, 4'h2, 32'h0);
      chk(q, 32'h0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_filter();
      wr(32'h0004_0004);
      filt(MIS, 1'b1);
      wr(32'h0000_0004);
      filt(STA, 1'b1);
      filt(MIS, 1'b0);
      filt(BC, 1'b1);
      wr(32'h0002_0004);
      filt(STA, 1'b0);
      filt(MIS, 1'b1);
      wr(32'h0000_0804);
      filt(BC, 1'b0);
      wr(32'h0008_0004);
      filt(MC, 1'b1);
      filt(MIS, 1'b0);
      hash_table_in = 64'hFFFF_FFFF_FFFF_FFFF;
      wr(32'h0000_2004);
      filt(MC, 1'b1);
      filt(MIS, 1'b0);
      filt(STA, 1'b1);
      wr(32'h0002_2004);
      filt(MIS, 1'b0);
      filt(MC, 1'b1);
      wr(32'h0000_8004);
      filt(MIS, 1'b1);
      hash_table_in = 64'h0;
      filt(STA, 1'b0);
      filt(MC, 1'b0);
      wr(32'h0004_0000);
      filt(MIS, 1'b0);
      $display("test filter done");
   endtask : t_filter

   task automatic t_frame();
      wr(32'h0000_0104);
      filt(STA, 1'b1);
      fend(3'b000, 16'h002D, 1'b1, 1'b1);
      fend(3'b000, 16'h002E, 1'b1, 1'b0);
      fend(3'b100, 16'h002E, 1'b0, 1'b0);
      wr(32'h0001_0104);
      fend(3'b010, 16'h002E, 1'b1, 1'b0);
      wr(32'h0000_0004);
      fend(3'b000, 16'h002D, 1'b1, 1'b0);
      $display("test frame done");
   endtask : t_frame

   task automatic t_tx();
      wr(32'h0000_0408);
      txe(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      txe(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'b01);
      wr(32'h0000_0008);
      txe(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      txe(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'b10);
      wr(32'h0000_1008);
      txe(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      txe(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'b10);
      wr(32'h0000_0008);
      txe(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      for (n = 0; n < 15; n++) begin
         txe(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'b00);
      end
      txe(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'b01);
      wr(32'h0010_0008);
      hb_fail_in = 1'b1;
      txe(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'b01);
      chk({hb_fail_out, two_way_out}, 2'b01);
      wr(32'h0000_0008);
      repeat (2) @(posedge clk_in);
      #1;
      chk({hb_fail_out, two_way_out}, 2'b10);
      @(negedge clk_in);
      hb_fail_in = 1'b0;
      $display("test tx done");
   endtask : t_tx

   task automatic t_mii();
      wr(32'h0000_000C);
      mac_tx_in = {1'b1, 4'hA};
      @(posedge clk_in);
      #1;
      chk({tx_go_out, phy_tx_out}, {1'b1, 1'b1, 4'hA});
      @(negedge clk_in);
      send = 1'b1;
      @(negedge clk_in);
      send = 1'b0;
      repeat (2) @(negedge clk_in);
      p = phy_rx_in;
      @(posedge clk_in);
      #1;
      chk({p.en, mac_rx_out}, {1'b1, p});
      wr(32'h0000_0004);
      repeat (2) @(posedge clk_in);
      #1;
      chk(phy_tx_out, 5'h0);
      @(negedge clk_in);
      mac_tx_in = '0;
      wr(32'h0000_0000);
      repeat (10) @(negedge clk_in);
      wr(32'h0020_0000);
      for (n = 0; n < 1001 && loop_busy_out !== 1'b0; n++) begin
         @(negedge clk_in);
      end
      chk(loop_busy_out, 1'b0);
      repeat (1000) @(negedge clk_in);
      wr(32'h0020_000C);
      n = seen;
      send = 1'b1;
      mac_tx_in = {1'b1, 4'h5};
      @(negedge clk_in);
      send = 1'b0;
      repeat (3) @(negedge clk_in);
      chk({mac_rx_out, phy_tx_out}, {1'b1, 4'h5, 5'h0});
      chk(seen, n);
      mac_tx_in = '0;
      $display("test mii done");
   endtask : t_mii

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end

   initial begin
      {csr_wr_in, csr_rd_in, dest_valid_in, rx_end_in, send} = '0;
      {tx_start_in, tx_coll_in, tx_late_in, hb_fail_in} = '0;
      {csr_index_in, csr_wdata_in, dest_addr_in} = '0;
      rx_end_info_in = '0;
      mac_tx_in = '0;
      station_addr_in = STA;
      hash_table_in = 64'h0;
      rst_in = 1'b1;
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      t_regs();
      t_filter();
      t_frame();
      t_tx();
      t_mii();
      wrap_up();
   end
endmodule : mrtmc_mode_control_tb_top

// ===== verif/mrtmc_phy_model.sv
// Behavioural model of the integrated PHY on the internal MII.
module mrtmc_phy_model (
   input  wire logic                  clk_in,
   input  wire logic                  send_in,
   input  wire mrtmc_pkg::mrtmc_mii_t phy_tx_in,
   output mrtmc_pkg::mrtmc_mii_t      phy_rx_out,
   output int                         seen_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] left_r = 4'h0;
   logic       en_r   = 1'b0;
   logic [3:0] d_r    = 4'h0;
   int         seen_r = 0;

   // Each output has a single driver; the state lives in the registers.
   assign phy_rx_out = {en_r, d_r};
   assign seen_out   = seen_r;

   always @(posedge clk_in) begin
      if (send_in) begin
         left_r <= 4'h8;
      end else if (left_r != 4'h0) begin
         left_r <= left_r - 4'h1;
      end
      en_r <= (left_r != 4'h0);
      // An idle line shows the inverse nibble so stale data never matches.
      d_r <= (left_r != 4'h0) ? left_r : ~d_r;
      if (phy_tx_in.en) begin
         seen_r <= seen_r + 1;
      end
   end
endmodule : mrtmc_phy_model
